// ### core/block_engine.sv
/*
  Iterative keyed block transform, one round per clock.
  Assumes go is a one-cycle pulse; a new go restarts the engine.
*/
`timescale 1ns/1ps
module block_engine
  import security_engine_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [BLOCK_W-1:0] key,
  input wire logic [BLOCK_W-1:0] block_in,
  output logic [BLOCK_W-1:0] result,
  output logic done
);

  typedef struct packed {
    logic [BLOCK_W-1:0] state;
    logic [BLOCK_W-1:0] round_key;
    logic [3:0] round;
    logic running;
    logic done;
  } eng_t;

  eng_t eng_reg;
  eng_t eng_next;

  always_comb
  begin
    eng_next = eng_reg;
    eng_next.done = 1'b0;
    if (go)
    begin
      eng_next.state = block_in;
      eng_next.round_key = key;
      eng_next.round = 4'h0;
      eng_next.running = 1'b1;
    end
    else if (eng_reg.running)
    begin
      eng_next.state = mix_round(eng_reg.state, eng_reg.round_key);
      eng_next.round_key = key_step(eng_reg.round_key);
      eng_next.round = eng_reg.round + 4'h1;
      if (eng_reg.round == 4'(ROUNDS - 1))
      begin
        eng_next.running = 1'b0;
        eng_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      eng_reg <= '0;
    else
      eng_reg <= eng_next;
  end

  assign result = eng_reg.state;
  assign done = eng_reg.done;

endmodule

// ### core/security_engine_control.sv
/*
  Register front end of the security engine: two control registers, a
  sixteen-byte data window routed onto internal memory segments, the
  operation sequencer and the self test.
  Assumes a single-master byte register port on ref_clk, strobes one
  cycle long, read data expected in the cycle after the read strobe.
*/
`timescale 1ns/1ps
// What this block does
// - writing clear one erases all memory segments
// - start launches operations chosen by mode bits
// - start in self-test mode runs self test
// - self-test mode bit sticky until software clears
// - ctr bit enables counter-mode encryption
// - cbc bit enables cbc-mac generation
// - aes bit enables plain block encryption
// - preload strobe loads mac accumulator from seed
// - select codes 0,1,2 pick key, data, counter
// - codes 3,4,6 pick ctr, cbc, aes results
// - code 5 picks mac seed; 7 reserved
// - pass flag zero at reset, one after pass
// - failed self test forces results to zero
// - sixteen byte window at 2Ah, resets zero
// - window byte zero is least significant byte
module security_engine_control
  import security_engine_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  output logic busy
);

  typedef struct packed {
    logic [SEG_COUNT-1:0][BLOCK_W-1:0] seg;
    logic [BLOCK_W-1:0] mac_acc;
    logic self_test;
    logic ctr_mode;
    logic cbc_mode;
    logic aes_mode;
    logic run_ctr;
    logic run_cbc;
    logic run_aes;
    logic [2:0] sel;
    logic pass;
    logic fail;
    op_t op;
    logic eng_go;
    logic [DATA_W-1:0] rd_data;
    logic busy;
  } ctl_t;

  ctl_t ctl_reg;
  ctl_t ctl_next;

  logic [BLOCK_W-1:0] eng_key;
  logic [BLOCK_W-1:0] eng_in;
  logic [BLOCK_W-1:0] eng_out;
  logic eng_done;

  // picks the next enabled operation after the given one
  function automatic op_t next_op(op_t after, logic ctr, logic cbc, logic aes);
    op_t n;
    n = OP_IDLE;
    case (after)
      OP_IDLE:
      begin
        if (ctr)
          n = OP_CTR;
        else if (cbc)
          n = OP_CBC;
        else if (aes)
          n = OP_AES;
      end
      OP_CTR:
      begin
        if (cbc)
          n = OP_CBC;
        else if (aes)
          n = OP_AES;
      end
      OP_CBC:
      begin
        if (aes)
          n = OP_AES;
      end
      default:
        n = OP_IDLE;
    endcase
    return n;
  endfunction

  function automatic logic is_result(logic [2:0] s);
    return (s == SEL_CTR_RES) || (s == SEL_CBC_RES) || (s == SEL_AES_RES);
  endfunction

  function automatic logic in_window(logic [ADDR_W-1:0] a);
    return (a >= OFF_DATA_BASE) && (a <= OFF_DATA_LAST);
  endfunction

  // byte lane of the window inside the selected segment
  function automatic logic [3:0] win_index(logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - OFF_DATA_BASE;
    return off[3:0];
  endfunction

  function automatic logic [DATA_W-1:0] get_byte(logic [BLOCK_W-1:0] b, logic [3:0] i);
    return b[i*DATA_W +: DATA_W];
  endfunction

  // lane zero is the least significant byte of the block
  function automatic logic [BLOCK_W-1:0] put_byte(logic [BLOCK_W-1:0] b, logic [3:0] i,
                                                  logic [DATA_W-1:0] v);
    logic [BLOCK_W-1:0] r;
    r = b;
    r[i*DATA_W +: DATA_W] = v;
    return r;
  endfunction

  // only key, data, counter and mac seed take window writes
  function automatic logic seg_writable(logic [2:0] s);
    return !is_result(s) && (s != SEL_RESERVED);
  endfunction

  // start takes the mode bits of the same write; self test overrides them
  function automatic op_t launch_op(logic [DATA_W-1:0] c);
    op_t n;
    if (c[C1_SELF_TEST])
      n = OP_TEST;
    else
      n = next_op(OP_IDLE, c[C1_CTR], c[C1_CBC], c[C1_AES]);
    return n;
  endfunction

  // a failed engine is unusable, so its results never leave the block
  function automatic logic [DATA_W-1:0] window_byte(logic [BLOCK_W-1:0] b, logic [2:0] s,
                                                    logic failed, logic [3:0] i);
    logic [DATA_W-1:0] v;
    if (s == SEL_RESERVED)
      v = '0;
    else if (is_result(s) && failed)
      v = '0;
    else
      v = get_byte(b, i);
    return v;
  endfunction

  // strobes and the reserved bit always read back as zero
  function automatic logic [DATA_W-1:0] ctrl1_image(logic st, logic ctr, logic cbc,
                                                    logic aes);
    logic [DATA_W-1:0] v;
    v = '0;
    v[C1_SELF_TEST] = st;
    v[C1_CTR] = ctr;
    v[C1_CBC] = cbc;
    v[C1_AES] = aes;
    return v;
  endfunction

  function automatic logic [DATA_W-1:0] ctrl2_image(logic [2:0] s, logic p);
    logic [DATA_W-1:0] v;
    v = '0;
    v[C2_SEL_HI:C2_SEL_LO] = s;
    v[C2_PASS] = p;
    return v;
  endfunction

  function automatic logic [BLOCK_W-1:0] ctr_result(logic [BLOCK_W-1:0] d,
                                                    logic [BLOCK_W-1:0] ks);
    return d ^ ks;
  endfunction

  function automatic logic self_test_ok(logic [BLOCK_W-1:0] r);
    return r == ST_EXPECT;
  endfunction

  // engine operands follow the running operation
  always_comb
  begin
    eng_key = ctl_reg.seg[SEL_KEY];
    eng_in = ctl_reg.seg[SEL_DATA];
    case (ctl_reg.op)
      OP_CTR:
        eng_in = ctl_reg.seg[SEL_CTR];
      OP_CBC:
        eng_in = ctl_reg.mac_acc ^ ctl_reg.seg[SEL_DATA];
      OP_TEST:
      begin
        eng_key = ST_KEY;
        eng_in = ST_DATA;
      end
      default:
        eng_in = ctl_reg.seg[SEL_DATA];
    endcase
  end

  block_engine u_engine (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .go(ctl_reg.eng_go),
    .key(eng_key),
    .block_in(eng_in),
    .result(eng_out),
    .done(eng_done)
  );

  always_comb
  begin
    logic [3:0] idx;
    op_t nxt;
    ctl_next = ctl_reg;
    ctl_next.eng_go = 1'b0;
    idx = win_index(addr);
    nxt = OP_IDLE;

    // sequencer: each operation launches the engine and waits for done
    if (eng_done && ctl_reg.op != OP_IDLE)
    begin
      case (ctl_reg.op)
        OP_CTR:
          ctl_next.seg[SEL_CTR_RES] = ctr_result(ctl_reg.seg[SEL_DATA], eng_out);
        OP_CBC:
        begin
          ctl_next.mac_acc = eng_out;
          ctl_next.seg[SEL_CBC_RES] = eng_out;
        end
        OP_AES:
          ctl_next.seg[SEL_AES_RES] = eng_out;
        OP_TEST:
        begin
          ctl_next.pass = self_test_ok(eng_out);
          ctl_next.fail = !self_test_ok(eng_out);
        end
        default:
          ctl_next.op = OP_IDLE;
      endcase
      if (ctl_reg.op == OP_TEST)
        nxt = OP_IDLE;
      else
        nxt = next_op(ctl_reg.op, ctl_reg.run_ctr, ctl_reg.run_cbc, ctl_reg.run_aes);
      ctl_next.op = nxt;
      ctl_next.eng_go = (nxt != OP_IDLE);
    end

    if (wr_en)
    begin
      if (addr == OFF_CONTROL_1)
      begin
        ctl_next.self_test = wr_data[C1_SELF_TEST];
        ctl_next.ctr_mode = wr_data[C1_CTR];
        ctl_next.cbc_mode = wr_data[C1_CBC];
        ctl_next.aes_mode = wr_data[C1_AES];
        if (wr_data[C1_MAC_PRELOAD])
          ctl_next.mac_acc = ctl_reg.seg[SEL_MAC];
        // start uses the mode bits written in the same access
        if (wr_data[C1_START] && ctl_reg.op == OP_IDLE)
        begin
          nxt = launch_op(wr_data);
          // the chain keeps the modes of its launch even if software rewrites them
          ctl_next.run_ctr = wr_data[C1_CTR];
          ctl_next.run_cbc = wr_data[C1_CBC];
          ctl_next.run_aes = wr_data[C1_AES];
          ctl_next.op = nxt;
          ctl_next.eng_go = (nxt != OP_IDLE);
        end
        if (wr_data[C1_CLEAR])
        begin
          // clear also abandons any operation in flight
          ctl_next.seg = '0;
          ctl_next.mac_acc = '0;
          ctl_next.op = OP_IDLE;
          ctl_next.eng_go = 1'b0;
        end
      end
      else if (addr == OFF_CONTROL_2)
        ctl_next.sel = wr_data[C2_SEL_HI:C2_SEL_LO];
      else if (in_window(addr))
      begin
        // results and the reserved code are not writable from the window
        if (seg_writable(ctl_reg.sel))
          ctl_next.seg[ctl_reg.sel] = put_byte(ctl_reg.seg[ctl_reg.sel], idx, wr_data);
      end
    end

    ctl_next.rd_data = '0;
    if (rd_en)
    begin
      if (addr == OFF_CONTROL_1)
      begin
        ctl_next.rd_data = ctrl1_image(ctl_reg.self_test, ctl_reg.ctr_mode, ctl_reg.cbc_mode,
                                       ctl_reg.aes_mode);
      end
      else if (addr == OFF_CONTROL_2)
      begin
        ctl_next.rd_data = ctrl2_image(ctl_reg.sel, ctl_reg.pass);
      end
      else if (in_window(addr))
      begin
        ctl_next.rd_data = window_byte(ctl_reg.seg[ctl_reg.sel], ctl_reg.sel, ctl_reg.fail,
                                       idx);
      end
    end

    ctl_next.busy = (ctl_next.op != OP_IDLE);
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ctl_reg <= '0;
    else
      ctl_reg <= ctl_next;
  end

  assign rd_data = ctl_reg.rd_data;
  assign busy = ctl_reg.busy;

endmodule

// ### core/security_engine_pkg.sv
/*
  Shared constants and types for the security engine register block:
  register offsets, control field positions, segment select codes,
  the stand-in block transform and the self-test vectors.
  Assumes an 8-bit register port with byte-wide registers.
*/
package security_engine_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int BLOCK_W = 128;
  localparam int WIN_BYTES = 16;
  localparam int SEG_COUNT = 7;
  localparam int ROUNDS = 10;

  localparam logic [ADDR_W-1:0] OFF_CONTROL_1 = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_CONTROL_2 = 8'h29;
  localparam logic [ADDR_W-1:0] OFF_DATA_BASE = 8'h2A;
  localparam logic [ADDR_W-1:0] OFF_DATA_LAST = 8'h39;

  // control 1 bit positions
  localparam int C1_CLEAR = 7;
  localparam int C1_START = 6;
  localparam int C1_SELF_TEST = 5;
  localparam int C1_CTR = 4;
  localparam int C1_CBC = 3;
  localparam int C1_AES = 2;
  localparam int C1_MAC_PRELOAD = 1;
  // control 2 field positions
  localparam int C2_SEL_HI = 7;
  localparam int C2_SEL_LO = 5;
  localparam int C2_PASS = 1;

  // data window select codes, equal to segment index
  localparam logic [2:0] SEL_KEY = 3'h0;
  localparam logic [2:0] SEL_DATA = 3'h1;
  localparam logic [2:0] SEL_CTR = 3'h2;
  localparam logic [2:0] SEL_CTR_RES = 3'h3;
  localparam logic [2:0] SEL_CBC_RES = 3'h4;
  localparam logic [2:0] SEL_MAC = 3'h5;
  localparam logic [2:0] SEL_AES_RES = 3'h6;
  localparam logic [2:0] SEL_RESERVED = 3'h7;

  localparam logic [BLOCK_W-1:0] ROUND_CONST = 128'h0000_0000_0000_0000_0000_0000_0000_001B;
  localparam logic [BLOCK_W-1:0] ST_KEY = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
  localparam logic [BLOCK_W-1:0] ST_DATA = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b000,
    OP_CTR = 3'b001,
    OP_CBC = 3'b010,
    OP_AES = 3'b011,
    OP_TEST = 3'b100
  } op_t;

  function automatic logic [BLOCK_W-1:0] mix_round(logic [BLOCK_W-1:0] s,
                                                   logic [BLOCK_W-1:0] k);
    logic [BLOCK_W-1:0] r1;
    logic [BLOCK_W-1:0] r8;
    r1 = {s[BLOCK_W-2:0], s[BLOCK_W-1]};
    r8 = {s[BLOCK_W-9:0], s[BLOCK_W-1:BLOCK_W-8]};
    return s ^ (r1 & r8) ^ {s[63:0], s[127:64]} ^ k;
  endfunction

  function automatic logic [BLOCK_W-1:0] key_step(logic [BLOCK_W-1:0] k);
    return {k[BLOCK_W-9:0], k[BLOCK_W-1:BLOCK_W-8]} ^ ROUND_CONST;
  endfunction

  function automatic logic [BLOCK_W-1:0] block_transform(logic [BLOCK_W-1:0] k,
                                                         logic [BLOCK_W-1:0] d);
    logic [BLOCK_W-1:0] s;
    logic [BLOCK_W-1:0] kk;
    s = d;
    kk = k;
    for (int i = 0; i < ROUNDS; i++)
    begin
      s = mix_round(s, kk);
      kk = key_step(kk);
    end
    return s;
  endfunction

  localparam logic [BLOCK_W-1:0] ST_EXPECT = block_transform(ST_KEY, ST_DATA);

endpackage

// ### testbench/security_engine_control_checker.sv
/*
  Port-level assertions for the security engine control block.
  Sees only the top module ports; bound to it at the foot of this file.
*/
`timescale 1ns/1ps
module security_engine_control_checker
  import security_engine_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic busy
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // clear in the same write is left out: it aborts the launch
  sequence go_seq;
    wr_en && addr == OFF_CONTROL_1 && wr_data[C1_START] && !wr_data[C1_CLEAR] && !busy
      && (|wr_data[5:2]);
  endsequence
  sequence run_seq;
    busy [*3] ##[1:40] !busy;
  endsequence
  sequence c1_echo_seq;
    (wr_en && addr == OFF_CONTROL_1 && !wr_data[C1_CLEAR] && !busy) ##2
      (rd_en && addr == OFF_CONTROL_1);
  endsequence

  a_start_busy: assert property (go_seq |=> run_seq)
    else $error("start did not run a bounded operation");
  a_busy_cause: assert property ($rose(busy) |->
    $past(wr_en) && $past(addr) == OFF_CONTROL_1 && $past(wr_data[C1_START]))
    else $error("busy rose without a start write");
  a_clear_abort: assert property (wr_en && addr == OFF_CONTROL_1 && wr_data[C1_CLEAR]
    && !wr_data[C1_START] |=> !busy)
    else $error("clear left engine busy");
  a_strobe_zero: assert property (rd_en && addr == OFF_CONTROL_1 |=>
    rd_data[7:6] == 2'h0 && !rd_data[1] && !rd_data[0])
    else $error("strobe bits read nonzero");
  a_ctrl2_rsvd: assert property (rd_en && addr == OFF_CONTROL_2 |=>
    rd_data[4:2] == 3'h0 && !rd_data[0])
    else $error("control 2 reserved bits nonzero");
  a_unmapped_zero: assert property (rd_en && (addr < OFF_CONTROL_1 || addr > OFF_DATA_LAST)
    |=> rd_data == 8'h00)
    else $error("unmapped read nonzero");
  a_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data without read strobe");
  a_mode_echo: assert property (c1_echo_seq |=>
    rd_data[5:2] == $past(wr_data[5:2], 3))
    else $error("mode bits not held as written");
endmodule

bind security_engine_control security_engine_control_checker chk (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .addr(addr),
  .wr_data(wr_data),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .rd_data(rd_data),
  .busy(busy)
);

// ### testbench/security_engine_control_test.sv
/*
  Self-checking bench for the security engine control block.
  Drives the register port directly; no model of the far side.
*/
`timescale 1ns/1ps
module security_engine_control_test;
  import security_engine_pkg::*;
  logic ref_clk, nrst, wr_en, rd_en, busy;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [BLOCK_W-1:0] k, v, aes, ctr, cbc;
  int error_cnt = 0;
  int checks_done = 0;

  security_engine_control dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .busy(busy));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [BLOCK_W-1:0] got, input logic [BLOCK_W-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= dv;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(negedge ref_clk);
    q = rd_data;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    rd(a, q);
    chk(q, e);
  endtask

  function automatic logic [BLOCK_W-1:0] pat(input int s);
    for (int i = 0; i < WIN_BYTES; i++)
      pat[8*i+:8] = 8'(16 * s + i);
  endfunction

  task automatic wblk(input logic [2:0] s, input logic [BLOCK_W-1:0] b);
    wr(OFF_CONTROL_2, {s, 5'h00});
    for (int i = 0; i < WIN_BYTES; i++)
      wr(OFF_DATA_BASE + 8'(i), b[8*i+:8]);
  endtask

  task automatic rblk(input logic [2:0] s, output logic [BLOCK_W-1:0] b);
    logic [7:0] q;
    wr(OFF_CONTROL_2, {s, 5'h00});
    for (int i = 0; i < WIN_BYTES; i++)
    begin
      rd(OFF_DATA_BASE + 8'(i), q);
      b[8*i+:8] = q;
    end
  endtask

  task automatic run(input logic [7:0] c);
    wr(OFF_CONTROL_1, c);
    @(negedge ref_clk);
    chk(busy, 1'b1);
    for (int i = 0; i < 80 && busy !== 1'b0; i++)
      @(negedge ref_clk);
    chk(busy, 1'b0);
  endtask

  task automatic test_reset();
    rchk(OFF_CONTROL_1, 8'h00);
    rchk(OFF_CONTROL_2, 8'h00);
    rchk(8'h3A, 8'h00);
    rblk(SEL_KEY, v);
    chk(v, '0);
  endtask

  task automatic test_self_test();
    run(8'h60);
    rchk(OFF_CONTROL_1, 8'h20);
    rchk(OFF_CONTROL_2, 8'h02);
    wr(OFF_CONTROL_1, 8'h00);
    rchk(OFF_CONTROL_1, 8'h00);
  endtask

  // result and reserved selects must ignore window writes
  task automatic test_window();
    for (int s = 0; s < 8; s++)
      wblk(3'(s), pat(s));
    for (int s = 0; s < 8; s++)
    begin
      rblk(3'(s), k);
      chk(k, (s inside {0, 1, 2, 5}) ? pat(s) : '0);
    end
  endtask

  // counter equal to data and a zero mac accumulator tie the cbc result and the ctr keystream to the plain one
  task automatic test_ops();
    wblk(SEL_CTR, pat(1));
    run(8'h5C);
    rblk(SEL_AES_RES, aes);
    rblk(SEL_CTR_RES, ctr);
    rblk(SEL_CBC_RES, cbc);
    chk(aes, block_transform(pat(0), pat(1)));
    chk(ctr, pat(1) ^ aes);
    chk(cbc, aes);
    wr(OFF_CONTROL_1, 8'h80);
    rblk(SEL_KEY, v);
    chk(v, '0);
    rblk(SEL_AES_RES, v);
    chk(v, '0);
  endtask

  task automatic test_preload();
    wblk(SEL_KEY, pat(0));
    wblk(SEL_MAC, pat(1));
    wr(OFF_CONTROL_1, 8'h02);
    run(8'h48);
    rblk(SEL_CBC_RES, v);
    chk(v, aes);
    rblk(SEL_AES_RES, v);
    chk(v, '0);
    rblk(SEL_CTR_RES, v);
    chk(v, '0);
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    nrst = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    test_reset();
    test_self_test();
    test_window();
    test_ops();
    test_preload();
    finish_test();
  end
endmodule
